// ### rtl/decim_params.svh
// Register offsets, field layout, reset values and timing counts of the decimator
// Contract
// - Above 16x: analog 16x, digital shift rest
// - Five-level thermometer code taken per sample
// - Raw mode: serial pin and result register
// - Raw mode: filter off, no ready
// - Raw mode: pin always driven
// - Four bits per sample, thermometer code mapping
// - Clock select 11 drives clock pin
// - Bitstream resets to 0011
// - Restart: pin high two clocks, then default
// - Bias field decoded to four levels
// - Sinc3 then sinc1, 24-bit result
// - Four-bit ratio field selects ratios
// - Conversion time per sinc3 and sinc1 ratios
// - Single mode: launch each, clear between
// - Continuous: no clear, result per ratio
// - Input swap doubles conversion time
// - High ratios give line-frequency notches
// - Ratio code table for both stages
// - Gain 110 doubles, 111 quadruples digitally
// - Swap with continuous clears between conversions
`ifndef DECIM_PARAMS_SVH
`define DECIM_PARAMS_SVH

`define ADDR_RESULT        8'h00
`define ADDR_CFG1          8'h04
`define ADDR_CFG2          8'h08
`define ADDR_CFG3          8'h0C
`define ADDR_MODE          8'h10
`define ADDR_CTRL          8'h14
`define ADDR_STATUS        8'h18

`define CFG1_OSR_LSB       0
`define CFG2_GAIN_LSB      0
`define CFG2_BIAS_LSB      3
`define CFG2_SWAP_BIT      5
`define CFG3_CMODE_LSB     0
`define MODE_IRQ_LSB       0
`define MODE_CLK_LSB       2
`define CTRL_START_BIT     0
`define CTRL_RESTART_BIT   1

`define OSR_RST            4'h3
`define GAIN_RST           3'h1
`define BIAS_RST           2'h2
`define CMODE_RST          2'h0
`define IRQ_MODE_RST       2'h0
`define CLK_SEL_RST        2'h0

`define CMODE_CONT         2'h3
`define CLK_SEL_OUT        2'h3
`define ANALOG_GAIN_MAX    3'h5
`define GAIN_X2            3'h6
`define GAIN_X4            3'h7

`define BITSTREAM_DEFAULT  4'h3
`define BIT_LAST           2'h3
`define SYNC_HOLD_LAST     2'h1
`define ANALOG_MASTER_CLOCK_DIV_DEFAULT  4
`define WARMUP_OUTPUTS     2'h2

`define SINC_ORDER         6'h3
`define MOD_FS_LOG2        6'h1
`define RESULT_FS_LOG2     6'h17
`define RECIP_FRAC         6'h12
`define RECIP_ONE          19'h40000
`define RECIP_THIRD        19'h15555
`define RECIP_FIFTH        19'h0CCCD

`endif

// ### rtl/decim_pkg.sv
// Types shared by the decimator files
`default_nettype none
package decim_pkg;
  typedef enum logic [0:0] {ST_SYNC, ST_RUN} seq_state_t;
  typedef struct packed {
    logic [3:0]  sinc3_ratio_log;
    logic [7:0]  sinc1_ratio;
    logic [2:0]  sinc1_ratio_log2;
    logic [18:0] recip;
  } ratio_cfg_t;
endpackage
`default_nettype wire

// ### rtl/gain_round_saturate.sv
// Output scaling with digital gain, rounding and saturation
`default_nettype none
`include "decim_params.svh"
module gain_round_saturate
  import decim_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        in_valid,
  input  wire logic [39:0] in_sum,
  input  wire logic [18:0] recip,
  input  wire logic [5:0]  shift,
  output logic             out_valid,
  output logic [23:0]      out_code
);
  logic signed [59:0] prod;
  logic signed [59:0] half;
  logic signed [59:0] scaled;
  logic               over_pos;
  logic               over_neg;
  logic [23:0]        next_code;

  assign prod = 60'($signed(in_sum) * $signed({1'b0, recip}));
  assign half = 60'sd1 <<< (shift - 6'h1);
  assign scaled = (prod + half) >>> shift;
  assign over_pos = scaled > 60'sh7FFFFF;
  assign over_neg = scaled < -60'sh800000;
  assign next_code = over_pos ? 24'h7FFFFF : over_neg ? 24'h800000 : scaled[23:0];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      out_valid <= 1'b0;
      out_code  <= 24'h000000;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_code <= next_code;
    end
  end
endmodule
`default_nettype wire

// ### rtl/sigma_delta_bitstream_decimator.sv
// Delta-sigma back end: bitstream output, sinc3/sinc1 decimator, register slave
`default_nettype none
`include "decim_params.svh"
module sigma_delta_bitstream_decimator
  import decim_pkg::*;
#(
  parameter int ANALOG_MASTER_CLOCK_DIV = `ANALOG_MASTER_CLOCK_DIV_DEFAULT
)
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  comp_code,
  output logic [2:0]       analog_gain_code,
  output logic [3:0]       bias_level,
  output logic             swap_inputs,
  output logic             sample_strobe,
  output logic             irq_bitstream_out,
  output logic             irq_bitstream_oe,
  output logic             mclk_out,
  output logic             mclk_oe
);
  localparam logic [7:0] DIV_LAST = 8'(ANALOG_MASTER_CLOCK_DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(ANALOG_MASTER_CLOCK_DIV / 2);

  // Register fields
  logic [3:0]  osr_code;
  logic [2:0]  gain_code;
  logic [1:0]  bias_a;
  logic        input_swap_offset_cancel;
  logic [1:0]  conversion_mode_select;
  logic [1:0]  irq_mode;
  logic [1:0]  clk_sel;
  logic [23:0] conversion_result;
  logic        data_ready;

  // Sequencer and link state
  seq_state_t  state;
  logic [1:0]  sync_cnt;
  logic [7:0]  div_cnt;
  logic [1:0]  bit_cnt;
  logic [3:0]  ser;
  logic        conv_on;
  logic        swap_phase;
  logic [39:0] sum_a;

  // Filter state
  logic signed [31:0] i1;
  logic signed [31:0] i2;
  logic signed [31:0] i3;
  logic signed [31:0] d1;
  logic signed [31:0] d2;
  logic signed [31:0] d3;
  logic [9:0]  s_cnt;
  logic [1:0]  warm;
  logic [7:0]  grp_cnt;
  logic [39:0] acc;

  // Bus decode
  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_cfg1   = bus_wr & (wb_adr_i == `ADDR_CFG1);
  wire wr_cfg2   = bus_wr & (wb_adr_i == `ADDR_CFG2);
  wire wr_cfg3   = bus_wr & (wb_adr_i == `ADDR_CFG3);
  wire wr_mode   = bus_wr & (wb_adr_i == `ADDR_MODE);
  wire wr_ctrl   = bus_wr & (wb_adr_i == `ADDR_CTRL);
  wire rd_result = bus_req & ~wb_we_i & (wb_adr_i == `ADDR_RESULT);
  wire start     = wr_ctrl & wb_dat_i[`CTRL_START_BIT];
  wire restart   = wr_cfg1 | wr_cfg2 | wr_cfg3 | wr_mode
                 | (wr_ctrl & wb_dat_i[`CTRL_RESTART_BIT]);

  logic [31:0] rd_data;
  always_comb
  begin
    case (wb_adr_i)
      `ADDR_RESULT: rd_data = {8'h00, conversion_result};
      `ADDR_CFG1:   rd_data = {28'h0, osr_code};
      `ADDR_CFG2:   rd_data = {26'h0, input_swap_offset_cancel, bias_a, gain_code};
      `ADDR_CFG3:   rd_data = {30'h0, conversion_mode_select};
      `ADDR_MODE:   rd_data = {28'h0, clk_sel, irq_mode};
      `ADDR_STATUS: rd_data = {29'h0, swap_phase, conv_on, data_ready};
      default:      rd_data = 32'h00000000;
    endcase
  end

  // Mode decode
  wire raw_mode  = irq_mode[1];
  wire cont_mode = conversion_mode_select == `CMODE_CONT;
  wire run       = state == ST_RUN;

  // Ratio table
  function automatic ratio_cfg_t decode_ratio(input logic [3:0] code);
    ratio_cfg_t r;
    r = '{sinc3_ratio_log: 4'h9, sinc1_ratio: 8'h01, sinc1_ratio_log2: 3'h0, recip: `RECIP_ONE};
    case (code)
      4'h0: r.sinc3_ratio_log = 4'h5;
      4'h1: r.sinc3_ratio_log = 4'h6;
      4'h2: r.sinc3_ratio_log = 4'h7;
      4'h3: r.sinc3_ratio_log = 4'h8;
      4'h4: r.sinc3_ratio_log = 4'h9;
      4'h5: r = '{4'h9, 8'h02, 3'h1, `RECIP_ONE};
      4'h6: r = '{4'h9, 8'h04, 3'h2, `RECIP_ONE};
      4'h7: r = '{4'h9, 8'h08, 3'h3, `RECIP_ONE};
      4'h8: r = '{4'h9, 8'h10, 3'h4, `RECIP_ONE};
      4'h9: r = '{4'h9, 8'h20, 3'h5, `RECIP_ONE};
      4'hA: r = '{4'h9, 8'h28, 3'h3, `RECIP_FIFTH};
      4'hB: r = '{4'h9, 8'h30, 3'h4, `RECIP_THIRD};
      4'hC: r = '{4'h9, 8'h50, 3'h4, `RECIP_FIFTH};
      4'hD: r = '{4'h9, 8'h60, 3'h5, `RECIP_THIRD};
      4'hE: r = '{4'h9, 8'hA0, 3'h5, `RECIP_FIFTH};
      4'hF: r = '{4'h9, 8'hC0, 3'h6, `RECIP_THIRD};
      default: r.sinc3_ratio_log = 4'h9;
    endcase
    return r;
  endfunction

  wire ratio_cfg_t ratio = decode_ratio(osr_code);
  wire [9:0] sinc3_ratio_last = 10'((10'h001 << ratio.sinc3_ratio_log) - 10'h001);
  wire [7:0] sinc1_ratio_last = ratio.sinc1_ratio - 8'h01;

  // Digital gain above the analog limit
  wire [5:0] dig_shift = (gain_code == `GAIN_X4) ? 6'h2 :
                         (gain_code == `GAIN_X2) ? 6'h1 : 6'h0;
  wire [5:0] norm_shift = `MOD_FS_LOG2 + `SINC_ORDER * 6'(ratio.sinc3_ratio_log)
                        + 6'(ratio.sinc1_ratio_log2) + `RECIP_FRAC - `RESULT_FS_LOG2
                        + 6'(input_swap_offset_cancel) - dig_shift;

  // Clock divider for analog master and sampling rates
  wire analog_master_clock_en  = run & (div_cnt == DIV_LAST);
  wire sample_en = analog_master_clock_en & (bit_cnt == `BIT_LAST);

  // Thermometer code to modulator level
  logic signed [2:0] level;
  always_comb
  begin
    case (comp_code)
      4'hF:    level = 3'sd2;
      4'h7:    level = 3'sd1;
      4'h3:    level = 3'sd0;
      4'h1:    level = -3'sd1;
      4'h0:    level = -3'sd2;
      default: level = 3'sd0;
    endcase
  end

  // Sinc3 integrators and combs
  wire filt_hold = ~run | raw_mode | ~conv_on;
  wire filt_step = ~filt_hold & sample_en;
  wire signed [31:0] x_ext = {{29{level[2]}}, level};
  wire signed [31:0] i1n = i1 + x_ext;
  wire signed [31:0] i2n = i2 + i1n;
  wire signed [31:0] i3n = i3 + i2n;
  wire signed [31:0] y1 = i3n - d1;
  wire signed [31:0] y2 = y1 - d2;
  wire signed [31:0] y3 = y2 - d3;
  wire dec_tick  = filt_step & (s_cnt == sinc3_ratio_last);
  wire warm_done = warm == `WARMUP_OUTPUTS;
  wire [39:0] y3_ext = {{8{y3[31]}}, y3};
  wire [39:0] acc_next = (grp_cnt == 8'h00) ? y3_ext : acc + y3_ext;
  wire emit = dec_tick & warm_done & (grp_cnt == sinc1_ratio_last);

  // Conversion sequencing
  wire first_half = emit & input_swap_offset_cancel & ~swap_phase;
  wire final_emit = emit & ~first_half;
  wire [39:0] final_sum = input_swap_offset_cancel ? sum_a - acc_next : acc_next;
  wire need_clr = first_half
                | (final_emit & (~cont_mode | input_swap_offset_cancel));
  wire filt_clr = sys_rst | restart | filt_hold | need_clr;

  wire        g_valid;
  wire [23:0] g_code;

  gain_round_saturate u_gain (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (final_emit),
    .in_sum    (final_sum),
    .recip     (ratio.recip),
    .shift     (norm_shift),
    .out_valid (g_valid),
    .out_code  (g_code)
  );

  // Pin drive
  wire next_pin_out = raw_mode ? ((state == ST_SYNC) | ser[3]) : 1'b0;
  wire next_pin_oe  = raw_mode | data_ready;
  wire next_mclk_oe = clk_sel == `CLK_SEL_OUT;

  // Register slave
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (bus_req)
        wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      osr_code                 <= `OSR_RST;
      gain_code                <= `GAIN_RST;
      bias_a                   <= `BIAS_RST;
      input_swap_offset_cancel <= 1'b0;
      conversion_mode_select   <= `CMODE_RST;
      irq_mode                 <= `IRQ_MODE_RST;
      clk_sel                  <= `CLK_SEL_RST;
    end
    else
    begin
      if (wr_cfg1)
        osr_code <= wb_dat_i[`CFG1_OSR_LSB +: 4];
      if (wr_cfg2)
      begin
        gain_code                <= wb_dat_i[`CFG2_GAIN_LSB +: 3];
        bias_a                   <= wb_dat_i[`CFG2_BIAS_LSB +: 2];
        input_swap_offset_cancel <= wb_dat_i[`CFG2_SWAP_BIT];
      end
      if (wr_cfg3)
        conversion_mode_select <= wb_dat_i[`CFG3_CMODE_LSB +: 2];
      if (wr_mode)
      begin
        irq_mode <= wb_dat_i[`MODE_IRQ_LSB +: 2];
        clk_sel  <= wb_dat_i[`MODE_CLK_LSB +: 2];
      end
    end
  end

  // Analog-facing controls
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      analog_gain_code <= `GAIN_RST;
      bias_level       <= 4'h4;
    end
    else
    begin
      analog_gain_code <= (gain_code > `ANALOG_GAIN_MAX) ? `ANALOG_GAIN_MAX : gain_code;
      bias_level       <= 4'h1 << bias_a;
    end
  end

  // Restart sequencer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst | restart)
    begin
      state    <= ST_SYNC;
      sync_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        ST_SYNC:
        begin
          sync_cnt <= sync_cnt + 2'h1;
          if (sync_cnt == `SYNC_HOLD_LAST)
            state <= ST_RUN;
        end
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_SYNC;
      endcase
    end
  end

  // Divider, serializer and clock pin
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst | restart)
    begin
      div_cnt  <= 8'h00;
      bit_cnt  <= 2'h0;
      ser      <= `BITSTREAM_DEFAULT;
      mclk_out <= 1'b0;
    end
    else
    begin
      if (run)
        div_cnt <= analog_master_clock_en ? 8'h00 : div_cnt + 8'h01;
      if (analog_master_clock_en)
        bit_cnt <= bit_cnt + 2'h1;
      if (sample_en)
        ser <= comp_code;
      else if (analog_master_clock_en)
        ser <= {ser[2:0], 1'b0};
      mclk_out <= run & (div_cnt < DIV_HALF);
    end
  end

  // Filter datapath
  always_ff @(posedge clk_sys)
  begin
    if (filt_clr)
    begin
      i1      <= 32'sh0;
      i2      <= 32'sh0;
      i3      <= 32'sh0;
      d1      <= 32'sh0;
      d2      <= 32'sh0;
      d3      <= 32'sh0;
      s_cnt   <= 10'h000;
      warm    <= 2'h0;
      grp_cnt <= 8'h00;
      acc     <= 40'h0000000000;
    end
    else if (filt_step)
    begin
      i1    <= i1n;
      i2    <= i2n;
      i3    <= i3n;
      s_cnt <= dec_tick ? 10'h000 : s_cnt + 10'h001;
      if (dec_tick)
      begin
        d1 <= i3n;
        d2 <= y1;
        d3 <= y2;
        if (!warm_done)
          warm <= warm + 2'h1;
        else
        begin
          acc     <= acc_next;
          grp_cnt <= (grp_cnt == sinc1_ratio_last) ? 8'h00 : grp_cnt + 8'h01;
        end
      end
    end
  end

  // Conversion control
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst | restart)
    begin
      conv_on    <= 1'b0;
      swap_phase <= 1'b0;
      sum_a      <= 40'h0000000000;
    end
    else
    begin
      if (first_half)
      begin
        sum_a      <= acc_next;
        swap_phase <= 1'b1;
      end
      if (final_emit)
      begin
        swap_phase <= 1'b0;
        if (!cont_mode)
          conv_on <= 1'b0;
      end
      if (start)
        conv_on <= 1'b1;
    end
  end

  // Result register and ready flag
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      conversion_result <= 24'h000000;
      data_ready        <= 1'b0;
    end
    else
    begin
      if (raw_mode & sample_en)
        conversion_result <= {20'h00000, comp_code};
      else if (g_valid & ~raw_mode)
        conversion_result <= g_code;
      if (g_valid & ~raw_mode)
        data_ready <= 1'b1;
      else if (rd_result | raw_mode)
        data_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_bitstream_out <= 1'b0;
      irq_bitstream_oe  <= 1'b0;
      mclk_oe           <= 1'b0;
      swap_inputs       <= 1'b0;
      sample_strobe     <= 1'b0;
    end
    else
    begin
      irq_bitstream_out <= next_pin_out;
      irq_bitstream_oe  <= next_pin_oe;
      mclk_oe           <= next_mclk_oe;
      swap_inputs       <= swap_phase;
      sample_strobe     <= sample_en;
    end
  end
endmodule
`default_nettype wire

// ### verif/decim_monitor.sv
// Assertion checker bound to the decimator top
`default_nettype none
module decim_monitor
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  analog_gain_code,
  input wire logic [3:0]  bias_level,
  input wire logic        irq_bitstream_out,
  input wire logic        irq_bitstream_oe,
  input wire logic        mclk_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic raw;
  wire  wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      raw <= 1'b0;
    else if (wr && wb_adr_i == 8'h10)
      raw <= wb_dat_i[1];
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence restart_wr;
    wr && wb_adr_i == 8'h14 && wb_dat_i[1];
  endsequence
  sequence sync_hold;
    irq_bitstream_out [*2];
  endsequence
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_next_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  gain_clip_a:
    assert property (wr && wb_adr_i == 8'h08 && wb_dat_i[2:0] > 3'h5 |-> ##2
      analog_gain_code == 3'h5) else $error("analog gain not clipped");
  bias_hot_a:
    assert property ($onehot(bias_level)) else $error("bias level not one-hot");
  raw_drive_a:
    assert property (raw [*4] |-> irq_bitstream_oe) else $error("pin released in raw mode");
  sync_high_a:
    assert property ((restart_wr ##0 raw) |-> ##1 sync_hold) else $error("no sync high");
  raw_ready_a:
    assert property (raw && wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> !wb_dat_o[0])
    else $error("ready raised in raw mode");
  mclk_drive_a:
    assert property (wr && wb_adr_i == 8'h10 && wb_dat_i[3:2] == 2'h3 |-> ##2 mclk_oe)
    else $error("clock pin not driven");
endmodule
bind sigma_delta_bitstream_decimator decim_monitor mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .analog_gain_code(analog_gain_code), .bias_level(bias_level), .mclk_oe(mclk_oe),
  .irq_bitstream_out(irq_bitstream_out), .irq_bitstream_oe(irq_bitstream_oe));
`default_nettype wire

// ### verif/host_bitstream_model.sv
// Comparator source and host bitstream receiver
`default_nettype none
module host_bitstream_model
#(
  parameter int ANALOG_MASTER_CLOCK_DIV = 2
)
(
  input  wire logic       clk_sys,
  input  wire logic       swap_inputs,
  input  wire logic       pin,
  input  wire logic       pin_oe,
  input  wire logic       arm,
  input  wire logic [3:0] code_in,
  output logic [3:0]      comp_code,
  output logic [7:0]      rx_bits,
  output logic [3:0]      rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic act;
  int   rel;
  wire  [3:0] neg = ~{code_in[0], code_in[1], code_in[2], code_in[3]};
  initial comp_code = 4'h3;
  always @(posedge clk_sys)
  begin
    comp_code <= swap_inputs ? neg : code_in;
    prev <= pin;
    if (arm)
    begin
      act      <= 1'b0;
      prev     <= 1'b0;
      rx_count <= 4'h0;
    end
    else if (!act && pin_oe && prev && !pin && rx_count == 4'h0)
    begin
      act <= 1'b1;
      rel <= 1;
    end
    else if (act)
    begin
      rel <= rel + 1;
      if (rel % ANALOG_MASTER_CLOCK_DIV == ANALOG_MASTER_CLOCK_DIV / 2)
      begin
        rx_bits  <= {rx_bits[6:0], pin};
        rx_count <= rx_count + 4'h1;
        act      <= (rx_count != 4'h7);
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the decimator
`default_nettype none
`include "decim_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, req = 1'b0, we = 1'b0, arm = 1'b1;
  logic [7:0]  adr = 8'h0, rx_bits;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [3:0]  code_in = 4'h3, comp_code, bias, rx_count;
  logic [2:0]  gain;
  logic        ack, swp, strobe, pin, oe, mclk, mclk_oe;
  int          num_errors = 0, checked = 0, scnt = 0, n, t0, t1;
  logic [3:0]  codes [5] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0};
  logic [7:0]  ra [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h40};
  logic [31:0] rv [6] = '{32'h3, 32'h11, 32'h0, 32'h0, 32'h0, 32'h0};
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (strobe === 1'b1)
      scnt <= scnt + 1;
  sigma_delta_bitstream_decimator #(.ANALOG_MASTER_CLOCK_DIV(DIV)) uut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .comp_code(comp_code),
    .analog_gain_code(gain), .bias_level(bias), .swap_inputs(swp), .sample_strobe(strobe),
    .irq_bitstream_out(pin), .irq_bitstream_oe(oe), .mclk_out(mclk), .mclk_oe(mclk_oe));
  host_bitstream_model #(.ANALOG_MASTER_CLOCK_DIV(DIV)) host (.clk_sys(clk_sys), .swap_inputs(swp),
    .pin(pin), .pin_oe(oe), .arm(arm), .code_in(code_in), .comp_code(comp_code),
    .rx_bits(rx_bits), .rx_count(rx_count));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? strobe : k == 1 ? oe : k == 2 ? ack : rx_count == 4'h8;
  endfunction
  task automatic wait_on(input int k, input int lim);
    int c;
    c = 0;
    do
    begin
      @(posedge clk_sys);
      c++;
    end
    while (pick(k) !== 1'b1 && c < lim);
    if (pick(k) !== 1'b1)
      chk("wait limit", 1, 0);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    wait_on(2, 40);
    q = rdat;
    req <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic conv(input logic [3:0] r, input logic [31:0] c2, input logic [3:0] c,
                      input int tq, input logic [31:0] e);
    code_in <= c;
    bus(1'b1, `ADDR_CFG1, {28'h0, r});
    bus(1'b1, `ADDR_CFG2, c2);
    wait_on(0, 40);
    bus(1'b1, `ADDR_CTRL, 32'h1);
    t0 = scnt;
    wait_on(1, 20000);
    t1 = scnt;
    chk("conversion time", tq, t1 - t0);
    bus(1'b0, `ADDR_RESULT, 32'h0);
    chk("result", e, {8'h0, q[23:0]});
    chk("analog gain", c2[2:0] > 3'h5 ? 3'h5 : c2[2:0], gain);
    $display("conversion test done");
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    chk("watchdog", 1, 0);
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("bias reset", 4'h4, bias);
    chk("gain reset", 3'h1, gain);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk("register reset", rv[i], q);
    end
    for (int b = 0; b < 4; b++)
    begin
      bus(1'b1, `ADDR_CFG2, {27'h0, b[1:0], 3'h1});
      @(posedge clk_sys);
      chk("bias level", 4'h1 << b, bias);
    end
    $display("register test done");
    bus(1'b1, `ADDR_MODE, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      code_in <= codes[i];
      arm <= 1'b1;
      bus(1'b1, `ADDR_CTRL, 32'h2);
      @(posedge clk_sys);
      arm <= 1'b0;
      wait_on(3, 200);
      chk("bitstream", {4'h3, codes[i]}, rx_bits);
      chk("pin enable", 1'b1, oe);
      bus(1'b0, `ADDR_RESULT, 32'h0);
      chk("raw result", codes[i], q[3:0]);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk("raw ready", 1'b0, q[0]);
    end
    bus(1'b1, `ADDR_MODE, 32'hE);
    repeat (4) @(posedge clk_sys);
    n = 0;
    repeat (8 * DIV)
    begin
      @(posedge clk_sys);
      n += mclk;
    end
    chk("clock pin enable", 1'b1, mclk_oe);
    chk("clock high count", 4 * DIV, n);
    bus(1'b1, `ADDR_MODE, 32'h0);
    $display("bitstream test done");
    conv(4'h0, 32'h11, 4'h7, 96, 32'h400000);
    conv(4'h0, 32'h16, 4'h7, 96, 32'h7FFFFF);
    conv(4'h0, 32'h17, 4'h1, 96, 32'h800000);
    conv(4'h0, 32'h31, 4'h7, 192, 32'h400000);
    conv(4'h5, 32'h11, 4'h7, 2048, 32'h400000);
    repeat (1000) @(posedge clk_sys);
    chk("single no rerun", 1'b0, oe);
    bus(1'b1, `ADDR_CFG3, 32'h3);
    conv(4'h0, 32'h11, 4'h7, 96, 32'h400000);
    wait_on(1, 2000);
    chk("pipelined interval", 32, scnt - t1);
    $display("continuous test done");
    final_report();
  end
endmodule
`default_nettype wire
